// ---- ewp_pkg.sv ----
package ewp_pkg;
   // What this block does
   // - Host detects completion only by comparing two consecutive reads.
   // - Host arms the lock with three command writes.
   // - Host issues command and data writes with page-write timing.
   // - While armed, every write must be prefixed by the arming sequence; the host prefixes only EWP_OP_ARM writes, EWP_OP_WRITE goes unprefixed.
   // - Host disarms the lock with a six-write command sequence.
   // - Host starts data loads within the byte_load_window after arming.

   localparam int CLK_MHZ = 100;
   localparam int ADDR_W = 15;
   localparam int DATA_W = 8;
   localparam int TOGGLE_BIT = 6;
   localparam int PAGE_BYTES = 64;
   // Strobe low time: must exceed 150 ns, well above the 20 ns noise filter; the code holds the strobe low for exactly 150 ns (15 cycles).
   localparam int STROBE_NS = 150;
   localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
   localparam int SETUP_NS = 50;
   localparam int SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;
   localparam int READ_NS = 300;
   localparam int READ_CYC = (READ_NS * CLK_MHZ + 999) / 1000;
   // Idle gap between loads; far below the 100 us byte_load_window.
   localparam int GAP_NS = 200;
   localparam int GAP_CYC = (GAP_NS * CLK_MHZ + 999) / 1000;
   localparam int WINDOW_US = 100;
   localparam int WINDOW_CYC = WINDOW_US * CLK_MHZ;
   localparam int LOCKOUT_MS = 10;
   localparam int LOCKOUT_CYC = LOCKOUT_MS * 1000 * CLK_MHZ;
   localparam int PROG_MS = 10;
   localparam int PROG_CYC = PROG_MS * 1000 * CLK_MHZ;
   localparam int CNT_W = 24;
   localparam int ARM_LEN = 3;
   localparam int DISARM_LEN = 6;
   localparam int SEQ_W = 3;

   typedef enum logic [1:0] {
      EWP_OP_WRITE = 2'h0,
      EWP_OP_ARM = 2'h1,
      EWP_OP_DISARM = 2'h2,
      EWP_OP_NONE = 2'h3
   } ewp_op_t;
endpackage

// ---- ewp_bus_cycle.sv ----
module ewp_bus_cycle (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_start,
   input wire logic i_write,
   input wire logic [ewp_pkg::ADDR_W-1:0] i_addr,
   input wire logic [ewp_pkg::DATA_W-1:0] i_wdata,
   input wire logic [ewp_pkg::DATA_W-1:0] i_dq_sync,
   output logic o_done,
   output logic [ewp_pkg::DATA_W-1:0] o_rdata,
   output logic [ewp_pkg::ADDR_W-1:0] o_a,
   output logic [ewp_pkg::DATA_W-1:0] o_dq_out,
   output logic o_dq_oe,
   output logic o_ce_n,
   output logic o_oe_n,
   output logic o_we_n
);
   typedef enum logic [1:0] {
      BC_IDLE = 2'b00,
      BC_SETUP = 2'b01,
      BC_PULSE = 2'b11,
      BC_GAP = 2'b10
   } ewp_bc_t;
   ewp_bc_t st, next_st;
   logic [7:0] cnt, next_cnt;
   logic wr, next_wr, done, next_done;
   logic [ewp_pkg::ADDR_W-1:0] a, next_a;
   logic [ewp_pkg::DATA_W-1:0] d, next_d, rd, next_rd;
   logic ce_n, next_ce_n, oe_n, next_oe_n, we_n, next_we_n, oe, next_oe;

   always_comb begin
      next_st = st;
      next_cnt = cnt;
      next_wr = wr;
      next_done = 1'b0;
      next_a = a;
      next_d = d;
      next_rd = rd;
      next_ce_n = ce_n;
      next_oe_n = oe_n;
      next_we_n = we_n;
      next_oe = oe;
      unique case (st)
         BC_IDLE: begin
            if (i_start) begin
               next_wr = i_write;
               next_a = i_addr;
               next_d = i_wdata;
               next_ce_n = 1'b0;
               next_oe_n = i_write;
               next_oe = i_write;
               next_cnt = 8'(ewp_pkg::SETUP_CYC);
               next_st = BC_SETUP;
            end
         end
         BC_SETUP: begin
            if (cnt <= 8'h01) begin
               // Strobe held low for full pulse time, beating noise filter.
               next_we_n = !wr;
               next_cnt = wr ? 8'(ewp_pkg::STROBE_CYC) : 8'(ewp_pkg::READ_CYC);
               next_st = BC_PULSE;
            end else begin
               next_cnt = cnt - 8'h01;
            end
         end
         BC_PULSE: begin
            if (cnt <= 8'h01) begin
               next_we_n = 1'b1;
               next_ce_n = 1'b1;
               next_oe_n = 1'b1;
               next_rd = i_dq_sync;
               next_cnt = 8'(ewp_pkg::GAP_CYC);
               next_st = BC_GAP;
            end else begin
               next_cnt = cnt - 8'h01;
            end
         end
         BC_GAP: begin
            next_oe = 1'b0;
            if (cnt <= 8'h01) begin
               next_done = 1'b1;
               next_st = BC_IDLE;
            end else begin
               next_cnt = cnt - 8'h01;
            end
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st <= BC_IDLE;
         cnt <= 8'h00;
         wr <= 1'b0;
         done <= 1'b0;
         a <= '0;
         d <= '0;
         rd <= '0;
         ce_n <= 1'b1;
         oe_n <= 1'b1;
         we_n <= 1'b1;
         oe <= 1'b0;
      end else begin
         st <= next_st;
         cnt <= next_cnt;
         wr <= next_wr;
         done <= next_done;
         a <= next_a;
         d <= next_d;
         rd <= next_rd;
         ce_n <= next_ce_n;
         oe_n <= next_oe_n;
         we_n <= next_we_n;
         oe <= next_oe;
      end
   end

   assign o_done = done;
   assign o_rdata = rd;
   assign o_a = a;
   assign o_dq_out = d;
   assign o_dq_oe = oe;
   assign o_ce_n = ce_n;
   assign o_oe_n = oe_n;
   assign o_we_n = we_n;
endmodule

// ---- ewp_host.sv ----
module ewp_host #(
   parameter int LOCKOUT_CYC = ewp_pkg::LOCKOUT_CYC,
   parameter int PROG_CYC = ewp_pkg::PROG_CYC,
   parameter int WINDOW_CYC = ewp_pkg::WINDOW_CYC,
   parameter logic [14:0] CMD_A1 = 15'h5555, // Command values are parameters.
   parameter logic [14:0] CMD_A2 = 15'h2aaa,
   parameter logic [7:0] CMD_D1 = 8'haa,
   parameter logic [7:0] CMD_D2 = 8'h55,
   parameter logic [7:0] ARM_D3 = 8'ha0,
   parameter logic [7:0] DIS_D3 = 8'h80,
   parameter logic [7:0] DIS_D6 = 8'h20
) (
   input wire logic I_CLK,
   input wire logic I_RST_N,
   input wire logic i_req,
   input wire logic [1:0] i_op,
   input wire logic [ewp_pkg::ADDR_W-1:0] i_addr,
   input wire logic [ewp_pkg::DATA_W-1:0] i_wdata,
   input wire logic [ewp_pkg::DATA_W-1:0] i_dq,
   output logic o_busy,
   output logic o_done,
   output logic o_timeout,
   output logic [ewp_pkg::ADDR_W-1:0] o_a,
   output logic [ewp_pkg::DATA_W-1:0] o_dq_out,
   output logic o_dq_oe,
   output logic o_ce_n,
   output logic o_oe_n,
   output logic o_we_n
);
   typedef enum logic [2:0] {
      H_INIT = 3'b000,
      H_IDLE = 3'b001,
      H_CMD = 3'b011,
      H_DATA = 3'b010,
      H_POLL = 3'b110,
      H_DONE = 3'b111
   } ewp_host_t;

   function automatic logic [22:0] cmd_word(input logic [1:0] op, input logic [2:0] idx);
      logic [22:0] w;
      w = {CMD_A1, CMD_D1};
      unique case (idx)
         3'h0: w = {CMD_A1, CMD_D1};
         3'h1: w = {CMD_A2, CMD_D2};
         3'h2: w = {CMD_A1, (op == 2'(ewp_pkg::EWP_OP_DISARM)) ? DIS_D3 : ARM_D3};
         3'h3: w = {CMD_A1, CMD_D1};
         3'h4: w = {CMD_A2, CMD_D2};
         default: w = {CMD_A1, DIS_D6};
      endcase
      return w;
   endfunction

   logic [ewp_pkg::DATA_W-1:0] dq_s1, dq_s2;
   ewp_host_t st, next_st;
   logic [ewp_pkg::CNT_W-1:0] tmr, next_tmr;
   logic [ewp_pkg::SEQ_W-1:0] idx, next_idx;
   logic [1:0] op, next_op;
   logic [ewp_pkg::ADDR_W-1:0] addr, next_addr;
   logic [ewp_pkg::DATA_W-1:0] wdat, next_wdat;
   logic have_prev, next_have_prev, prev6, next_prev6;
   logic busy, next_busy, done, next_done, tout, next_tout;
   logic cyc_start, cyc_write, cyc_done;
   logic [ewp_pkg::ADDR_W-1:0] cyc_addr;
   logic [ewp_pkg::DATA_W-1:0] cyc_wdata, cyc_rdata;
   logic [22:0] cw;

   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         dq_s1 <= '0;
         dq_s2 <= '0;
      end else begin
         dq_s1 <= i_dq;
         dq_s2 <= dq_s1;
      end
   end

   always_comb begin
      cw = cmd_word(op, idx);
      next_st = st;
      next_tmr = tmr;
      next_idx = idx;
      next_op = op;
      next_addr = addr;
      next_wdat = wdat;
      next_have_prev = have_prev;
      next_prev6 = prev6;
      next_busy = busy;
      next_done = 1'b0;
      next_tout = tout;
      cyc_start = 1'b0;
      cyc_write = 1'b1;
      cyc_addr = cw[22:8];
      cyc_wdata = cw[7:0];
      unique case (st)
         H_INIT: begin
            // Wait out the chip's power-up write lockout before any write.
            if (tmr >= ewp_pkg::CNT_W'(LOCKOUT_CYC)) begin
               next_busy = 1'b0;
               next_st = H_IDLE;
            end else begin
               next_tmr = tmr + 1'b1;
            end
         end
         H_IDLE: begin
            if (i_req && i_op != 2'(ewp_pkg::EWP_OP_NONE)) begin
               next_op = i_op;
               next_addr = i_addr;
               next_wdat = i_wdata;
               next_idx = '0;
               next_busy = 1'b1;
               next_tout = 1'b0;
               next_st = (i_op == 2'(ewp_pkg::EWP_OP_WRITE)) ? H_DATA : H_CMD;
               cyc_start = 1'b0;
            end
         end
         H_CMD: begin
            // Arm prefix is three writes; disarm is six, back to back.
            cyc_start = 1'b1;
            if (cyc_done) begin
               cyc_start = 1'b0;
               if ((op == 2'(ewp_pkg::EWP_OP_DISARM) && idx == 3'(ewp_pkg::DISARM_LEN - 1))
                   || (op != 2'(ewp_pkg::EWP_OP_DISARM) && idx == 3'(ewp_pkg::ARM_LEN - 1)))
                  // After the arm prefix, data follows inside the load window; after disarm, polling starts.
                  next_st = (op == 2'(ewp_pkg::EWP_OP_ARM)) ? H_DATA : H_POLL;
               else
                  next_idx = idx + 1'b1;
               next_tmr = '0;
               next_have_prev = 1'b0;
            end
         end
         H_DATA: begin
            // Armed-lock writes are prefixed above; plain writes go direct.
            cyc_start = 1'b1;
            cyc_addr = addr;
            cyc_wdata = wdat;
            if (cyc_done) begin
               cyc_start = 1'b0;
               next_tmr = '0;
               next_have_prev = 1'b0;
               next_st = H_POLL;
            end
         end
         H_POLL: begin
            // Completion only when two consecutive reads agree on bit 6.
            // Reads wait out the byte_load_window, or stale data would pass as done.
            cyc_start = (tmr >= ewp_pkg::CNT_W'(WINDOW_CYC));
            cyc_write = 1'b0;
            cyc_addr = addr;
            next_tmr = tmr + 1'b1;
            if (cyc_done) begin
               cyc_start = 1'b0;
               next_have_prev = 1'b1;
               next_prev6 = cyc_rdata[ewp_pkg::TOGGLE_BIT];
               if (have_prev && prev6 == cyc_rdata[ewp_pkg::TOGGLE_BIT])
                  next_st = H_DONE;
            end
            // Give up past the programming limit plus one load window.
            if (tmr >= ewp_pkg::CNT_W'(PROG_CYC + WINDOW_CYC)) begin
               next_tout = 1'b1;
               next_st = H_DONE;
            end
         end
         H_DONE: begin
            next_busy = 1'b0;
            next_done = 1'b1;
            next_st = H_IDLE;
         end
         default: next_st = H_IDLE;
      endcase
   end

   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         st <= H_INIT;
         tmr <= '0;
         idx <= '0;
         op <= 2'h0;
         addr <= '0;
         wdat <= '0;
         have_prev <= 1'b0;
         prev6 <= 1'b0;
         busy <= 1'b1;
         done <= 1'b0;
         tout <= 1'b0;
      end else begin
         st <= next_st;
         tmr <= next_tmr;
         idx <= next_idx;
         op <= next_op;
         addr <= next_addr;
         wdat <= next_wdat;
         have_prev <= next_have_prev;
         prev6 <= next_prev6;
         busy <= next_busy;
         done <= next_done;
         tout <= next_tout;
      end
   end

   ewp_bus_cycle u_cycle (
      .i_clk(I_CLK),
      .i_rst_n(I_RST_N),
      .i_start(cyc_start),
      .i_write(cyc_write),
      .i_addr(cyc_addr),
      .i_wdata(cyc_wdata),
      .i_dq_sync(dq_s2),
      .o_done(cyc_done),
      .o_rdata(cyc_rdata),
      .o_a(o_a),
      .o_dq_out(o_dq_out),
      .o_dq_oe(o_dq_oe),
      .o_ce_n(o_ce_n),
      .o_oe_n(o_oe_n),
      .o_we_n(o_we_n)
   );

   assign o_busy = busy;
   assign o_done = done;
   assign o_timeout = tout;
endmodule

// ---- ewp_host_checker.sv ----
module ewp_host_checker (
   input wire logic I_CLK,
   input wire logic I_RST_N,
   input wire logic i_req,
   input wire logic [1:0] i_op,
   input wire logic o_busy,
   input wire logic o_done,
   input wire logic o_timeout,
   input wire logic [ewp_pkg::ADDR_W-1:0] o_a,
   input wire logic [ewp_pkg::DATA_W-1:0] o_dq_out,
   input wire logic o_dq_oe,
   input wire logic o_ce_n,
   input wire logic o_oe_n,
   input wire logic o_we_n
);
   logic [4:0] lo_cnt;
   logic [4:0] next_lo_cnt;
   always_comb begin
      next_lo_cnt = o_we_n ? 5'h0 : lo_cnt + 5'h1;
   end
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         lo_cnt <= 5'h0;
      end else begin
         lo_cnt <= next_lo_cnt;
      end
   end
   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (!I_RST_N);
   sequence s_take;
      i_req && !o_busy && i_op != 2'h3;
   endsequence
   sequence s_hold;
      (!o_we_n && !o_ce_n && o_dq_oe && $stable(o_a) && $stable(o_dq_out)) [*8];
   endsequence
   busy_reset_a: assert property ($rose(I_RST_N) |-> o_busy)
      else $error("busy low after reset");
   take_busy_a: assert property (s_take |=> o_busy)
      else $error("request not taken");
   tmo_clear_a: assert property (s_take |=> !o_timeout)
      else $error("timeout kept after request");
   done_once_a: assert property (o_done |=> !o_done)
      else $error("done longer than one cycle");
   we_width_a: assert property ($rose(o_we_n) |-> lo_cnt == ewp_pkg::STROBE_CYC)
      else $error("strobe width wrong");
   we_hold_a: assert property ($fell(o_we_n) |-> s_hold)
      else $error("write lines moved in strobe");
   we_setup_a: assert property ($fell(o_we_n) |-> !$past(o_ce_n, 4) && o_oe_n)
      else $error("strobe without setup");
   read_quiet_a: assert property (!o_oe_n |-> !o_dq_oe && o_we_n)
      else $error("bus driven during read");
   dq_free_a: assert property ($rose(o_we_n) |=> !o_dq_oe && o_ce_n)
      else $error("bus held after write");
   load_gap_a: assert property ($rose(o_we_n) |-> o_we_n [*8])
      else $error("strobe gap too short");
endmodule

bind ewp_host ewp_host_checker ewp_host_checker_i (.I_CLK(I_CLK), .I_RST_N(I_RST_N),
   .i_req(i_req), .i_op(i_op), .o_busy(o_busy), .o_done(o_done), .o_timeout(o_timeout),
   .o_a(o_a), .o_dq_out(o_dq_out), .o_dq_oe(o_dq_oe), .o_ce_n(o_ce_n), .o_oe_n(o_oe_n),
   .o_we_n(o_we_n));

// ---- ewp_eeprom_model.sv ----
module ewp_eeprom_model #(
   parameter logic [14:0] CMD_A1 = 15'h5555,
   parameter logic [14:0] CMD_A2 = 15'h2aaa,
   parameter logic [7:0] CMD_D1 = 8'haa,
   parameter logic [7:0] CMD_D2 = 8'h55,
   parameter logic [7:0] ARM_D3 = 8'ha0,
   parameter logic [7:0] DIS_D3 = 8'h80,
   parameter logic [7:0] DIS_D6 = 8'h20,
   parameter int LOCK_NS = 450,
   parameter int LOAD_NS = 1000
) (
   input wire logic [14:0] i_a,
   input wire logic [7:0] i_dq,
   input wire logic i_ce_n,
   input wire logic i_oe_n,
   input wire logic i_we_n,
   output logic [7:0] o_dq
);
   timeunit 1ns;
   timeprecision 100ps;
   // Command values are parameters so the host and this model agree.
   logic [7:0] mem [0:32767];
   logic [22:0] hist [0:5];
   logic [22:0] pg [$];
   logic armed = 1'b0;
   logic win = 1'b0;
   logic pend = 1'b0;
   logic prog = 1'b0;
   logic tog = 1'b0;
   logic low_vcc = 1'b0;
   logic [7:0] last = 8'h00;
   int prog_ns = 5000;
   time t_fall = 0;
   time t_load = 0;
   wire logic wr_n = i_ce_n | i_we_n | ~i_oe_n;
   initial begin
      foreach (mem[i]) mem[i] = 8'hff;
   end
   task automatic load(input logic [22:0] e);
      for (int i = 0; i < 5; i++) hist[i] = hist[i + 1];
      hist[5] = e;
      t_load = $time;
      if ({hist[3], hist[4], hist[5]} == {CMD_A1, CMD_D1, CMD_A2, CMD_D2, CMD_A1, ARM_D3}) begin
         {armed, win, pend} = 3'b111;
         pg.delete();
      end else if ({hist[0], hist[1], hist[2], hist[3], hist[4], hist[5]} == {CMD_A1, CMD_D1,
            CMD_A2, CMD_D2, CMD_A1, DIS_D3, CMD_A1, CMD_D1, CMD_A2, CMD_D2, CMD_A1, DIS_D6}) begin
         {armed, win, pend} = 3'b001;
         pg.delete();
      end else if ((!armed || win) && pg.size() < 64) begin
         pg.push_back(e);
         pend = 1'b1;
      end
   endtask
   always @(negedge wr_n) t_fall = $time;
   // Loads during programming are dropped, as the real part is deaf then.
   always @(posedge wr_n) begin
      if ($time - t_fall >= 20 && !prog && !low_vcc && $time >= LOCK_NS) begin
         load({i_a, i_dq});
      end
   end
   always begin
      wait (pend);
      while ($time - t_load < LOAD_NS) #(LOAD_NS - ($time - t_load));
      while (pg.size() > 0) begin
         mem[pg[0][22:8]] = pg[0][7:0];
         void'(pg.pop_front());
      end
      {pend, win, prog} = 3'b001;
      #(prog_ns);
      prog = 1'b0;
   end
   always @(negedge (i_ce_n | i_oe_n)) if (prog) tog = ~tog;
   always @(i_ce_n, i_oe_n, i_we_n, i_a, prog, tog) begin
      if (!i_ce_n && !i_oe_n && i_we_n) begin
         o_dq = mem[i_a];
         if (prog) o_dq[ewp_pkg::TOGGLE_BIT] = tog;
         last = o_dq;
      end else begin
         o_dq = ~last;
      end
   end
endmodule

// ---- eeprom_write_protect_status_bench.sv ----
module eeprom_write_protect_status_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic I_CLK = 1'b0;
   logic I_RST_N = 1'b0;
   logic i_req = 1'b0;
   logic [1:0] i_op = 2'h3;
   logic [14:0] i_addr = 15'h0;
   logic [7:0] i_wdata = 8'h0;
   logic [7:0] m_dq;
   logic [7:0] dq_bus;
   logic [14:0] o_a;
   logic [7:0] o_dq_out;
   logic o_busy, o_done, o_timeout, o_dq_oe, o_ce_n, o_oe_n, o_we_n;
   int error_cnt = 0;
   int compares = 0;
   always #5 I_CLK = ~I_CLK;
   assign dq_bus = o_dq_oe ? o_dq_out : m_dq;
   ewp_host #(.LOCKOUT_CYC(50), .PROG_CYC(2000), .WINDOW_CYC(500)) ewp_host_i (
      .I_CLK(I_CLK), .I_RST_N(I_RST_N), .i_req(i_req), .i_op(i_op), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_dq(dq_bus), .o_busy(o_busy), .o_done(o_done),
      .o_timeout(o_timeout), .o_a(o_a), .o_dq_out(o_dq_out), .o_dq_oe(o_dq_oe),
      .o_ce_n(o_ce_n), .o_oe_n(o_oe_n), .o_we_n(o_we_n));
   ewp_eeprom_model ewp_eeprom_model_i (.i_a(o_a), .i_dq(o_dq_out), .i_ce_n(o_ce_n),
      .i_oe_n(o_oe_n), .i_we_n(o_we_n), .o_dq(m_dq));
   task end_sim;
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task chk(input logic ok, input string msg);
      compares++;
      if (ok !== 1'b1) begin
         error_cnt++;
         $display("Error at %0t: %s", $time, msg);
      end
   endtask
   task wait_idle;
      for (int n = 0; n < 300 && o_busy !== 1'b0; n++) @(negedge I_CLK);
      chk(o_busy === 1'b0, "host stays busy");
   endtask
   task do_op(input logic [1:0] op, input logic [14:0] a, input logic [7:0] d);
      @(negedge I_CLK);
      i_req = 1'b1;
      i_op = op;
      i_addr = a;
      i_wdata = d;
      @(negedge I_CLK);
      i_req = 1'b0;
      for (int n = 0; n < 5000 && o_done !== 1'b1; n++) @(negedge I_CLK);
      chk(o_done === 1'b1, "no done");
      // Done while the part still programs is legal only as a timeout.
      chk((ewp_eeprom_model_i.prog === 1'b1) === (o_timeout === 1'b1), "done before write ended");
   endtask
   task t_reset;
      @(negedge I_CLK);
      chk(o_busy === 1'b1 && o_we_n === 1'b1 && o_dq_oe === 1'b0, "reset state");
      wait_idle();
   endtask
   task t_plain;
      fork
         do_op(2'h0, 15'h0100, 8'h11);
         begin
            repeat (10) @(negedge I_CLK);
            i_req = 1'b1;
            i_addr = 15'h0200;
            @(negedge I_CLK);
            i_req = 1'b0;
         end
      join
      chk(ewp_eeprom_model_i.mem[15'h0100] === 8'h11, "plain write lost");
      chk(ewp_eeprom_model_i.mem[15'h0200] === 8'hff, "busy request taken");
      chk(o_timeout === 1'b0, "timeout on quick write");
   endtask
   task t_arm;
      do_op(2'h1, 15'h0300, 8'h3c);
      chk(ewp_eeprom_model_i.armed === 1'b1, "lock not armed");
      chk(ewp_eeprom_model_i.mem[15'h0300] === 8'h3c, "armed data lost");
      chk(ewp_eeprom_model_i.mem[15'h5555] === 8'hff, "command stored");
   endtask
   task t_locked;
      @(negedge I_CLK);
      I_RST_N = 1'b0;
      repeat (2) @(negedge I_CLK);
      I_RST_N = 1'b1;
      wait_idle();
      chk(ewp_eeprom_model_i.armed === 1'b1, "lock lost on reset");
      do_op(2'h0, 15'h0301, 8'h77);
      chk(ewp_eeprom_model_i.mem[15'h0301] === 8'hff, "locked write stored");
   endtask
   task t_disarm;
      do_op(2'h2, 15'h0000, 8'h00);
      chk(ewp_eeprom_model_i.armed === 1'b0, "lock still armed");
      do_op(2'h0, 15'h0302, 8'h99);
      chk(ewp_eeprom_model_i.mem[15'h0302] === 8'h99, "write after disarm lost");
      ewp_eeprom_model_i.low_vcc = 1'b1;
      do_op(2'h0, 15'h0303, 8'h66);
      ewp_eeprom_model_i.low_vcc = 1'b0;
      chk(ewp_eeprom_model_i.mem[15'h0303] === 8'hff, "write at low supply stored");
   endtask
   task t_slow;
      ewp_eeprom_model_i.prog_ns = 30000;
      do_op(2'h0, 15'h0400, 8'h5a);
      chk(o_timeout === 1'b1, "no timeout on slow part");
      wait (ewp_eeprom_model_i.prog === 1'b0);
      ewp_eeprom_model_i.prog_ns = 5000;
      do_op(2'h0, 15'h0401, 8'ha5);
      chk(o_timeout === 1'b0, "timeout not cleared");
      chk(ewp_eeprom_model_i.mem[15'h0401] === 8'ha5, "write lost");
   endtask
   initial begin
      #500us;
      error_cnt++;
      $display("Error at %0t: watchdog expired", $time);
      end_sim();
   end
   initial begin
      repeat (2) @(negedge I_CLK);
      I_RST_N = 1'b1;
      t_reset();
      t_plain();
      t_arm();
      t_locked();
      t_disarm();
      t_slow();
      end_sim();
   end
endmodule
